// *** logic/adcs_top.v ***
// Converter control: AHB-Lite register slave, clock choice and sequencing
//
// Contract
// R1: Port register reads the eight pin levels.
// R2: Converter off: pins are plain digital inputs.
// R3: Result register loads at completion, resets zero.
// R4: Port reads still work while converting.
// R5: Set done flag, restart conversion continuously.
// R6: Result read or control write clears flag.
// R7: Reset clears the done flag.
// R8: RC select runs oscillator, clocks conversions.
// R9: Decode power and RC bits into four modes.
// R10: Reset clears the RC select bit.
// R11: Power bit switches converter; reset clears it.
// R12: Channel codes: inputs, high, mid, low.
// R13: Reset clears channel select to input zero.
// R14: Stop disables converter, clocks and oscillator.
// R15: Wait mode leaves conversion unchanged.
// R16: Software may clear bits before wait.
// R17: Sample switch closed exactly twelve bus cycles.
// R18: Control write aborts and restarts conversion.
// R19: One eight-bit approximation, bit per step.
// R20: Bit four reads zero; done flag read-only.
// R21: Power off holds sequencer idle, no flags.
`default_nettype none
`include "adcs_regs.vh"

module adcs_top (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Pins and system state
    input  wire [7:0]  analog_port_pins,
    input  wire        stop_mode,
    input  wire        rc_osc_tick,
    // Analog front end
    input  wire        comp_high,
    output reg         adc_enable,
    output reg         rc_osc_enable,
    output wire [10:0] mux_select,
    output wire        sample_switch,
    output wire [7:0]  dac_code
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode

    localparam SEL_NONE   = 4'b0001;
    localparam SEL_PORT   = 4'b0010;
    localparam SEL_RESULT = 4'b0100;
    localparam SEL_CTRL   = 4'b1000;

    // Map a byte offset onto one of the three registers
    function [3:0] reg_select;
        input [7:0] addr;
        begin
            if (addr == `ADCS_PORT_ADDR) begin
                reg_select = SEL_PORT;
            end else if (addr == `ADCS_RESULT_ADDR) begin
                reg_select = SEL_RESULT;
            end else if (addr == `ADCS_CTRL_ADDR) begin
                reg_select = SEL_CTRL;
            end else begin
                reg_select = SEL_NONE;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    wire        accept;
    wire [3:0]  addr_sel;
    wire        rd_accept;
    wire        rd_result;
    wire        wr_ctrl;
    wire        run;
    wire        step_en;
    wire        conv_done;
    wire [7:0]  conv_code;
    wire [31:0] hsize_unused;

    reg         wr_pend_q;
    reg  [3:0]  wr_sel_q;

    reg         rc_sel_q;
    reg         rc_sel_d;
    reg         pwr_on_q;
    reg         pwr_on_d;
    reg  [3:0]  chan_q;
    reg  [3:0]  chan_d;
    reg         done_q;
    reg         done_d;
    reg  [7:0]  result_q;
    reg  [7:0]  result_d;
    reg  [7:0]  ctrl_view;
    reg  [31:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // Bus phase tracking

    // A transfer is taken when selected, NONSEQ or SEQ, and bus ready
    assign accept    = hsel & htrans[1] & hready;
    assign addr_sel  = reg_select(haddr[7:0]);
    assign rd_accept = accept & ~hwrite;
    assign rd_result = rd_accept & (addr_sel == SEL_RESULT);

    // Only whole-word transfers are issued, so size is not decoded
    assign hsize_unused = {29'h0, hsize};

    // Write data arrive one cycle after the address phase
    assign wr_ctrl = wr_pend_q & (wr_sel_q == SEL_CTRL);

    // Remember a taken write until its data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_sel_q  <= SEL_NONE;
        end else begin
            wr_pend_q <= accept & hwrite;
            wr_sel_q  <= addr_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control/status register next values

    // Software-writable fields; bit four and the flag are not stored
    always @* begin
        rc_sel_d = rc_sel_q;
        pwr_on_d = pwr_on_q;
        chan_d   = chan_q;
        if (wr_ctrl) begin
            rc_sel_d = hwdata[`ADCS_RCSEL_BIT];                // see R8
            pwr_on_d = hwdata[`ADCS_PWR_BIT];                  // see R11
            chan_d   = hwdata[`ADCS_CHAN_MSB:`ADCS_CHAN_LSB];  // see R20
        end
    end

    // Completion sets the flag and wins over a simultaneous clear
    always @* begin
        done_d = conv_done | (done_q & ~(rd_result | wr_ctrl));  // see R6
    end

    // Result loaded from the approximation register at completion
    always @* begin
        result_d = conv_done ? conv_code : result_q;          // see R3
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    // Reset clears every control bit, the flag and the result
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_sel_q <= 1'b0;                     // see R10
            pwr_on_q <= 1'b0;                     // see R11
            chan_q   <= `ADCS_CHAN_RST;           // see R13
            done_q   <= 1'b0;                     // see R7
            result_q <= `ADCS_RESULT_RST;         // see R3
        end else begin
            rc_sel_q <= rc_sel_d;
            pwr_on_q <= pwr_on_d;
            chan_q   <= chan_d;
            done_q   <= done_d;                   // see R5
            result_q <= result_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    // Control view built from next values so a read after a write is fresh
    always @* begin
        ctrl_view                  = 8'h00;
        ctrl_view[`ADCS_DONE_BIT]  = done_d;
        ctrl_view[`ADCS_RCSEL_BIT] = rc_sel_d;
        ctrl_view[`ADCS_PWR_BIT]   = pwr_on_d;
        ctrl_view[`ADCS_RSVD_BIT]  = 1'b0;                     // see R20
        ctrl_view[`ADCS_CHAN_MSB:`ADCS_CHAN_LSB] = chan_d;
    end

    // Read mux; unmapped offsets read as zero
    always @* begin
        rdata_d = 32'h0000_0000;
        if (addr_sel == SEL_PORT) begin
            rdata_d = {24'h00_0000, analog_port_pins};  // see R1, R2, R4
        end else if (addr_sel == SEL_RESULT) begin
            rdata_d = {24'h00_0000, result_d};
        end else if (addr_sel == SEL_CTRL) begin
            rdata_d = {24'h00_0000, ctrl_view};
        end
    end

    // Read data captured at the address phase, held through data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_accept) begin
            hrdata <= rdata_d;
        end
    end

    // Zero-wait slave, always OKAY
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= hsize_unused[31];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and clock choice

    // Stop shuts the converter and the oscillator; wait is not an input
    assign run = pwr_on_d & ~stop_mode;            // see R14, R15, R21

    // RC select with power on steps on oscillator ticks, else bus clock
    assign step_en = rc_sel_q ? rc_osc_tick : 1'b1;             // see R8

    // Off/off, CPU clock, oscillator only, RC clock
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adc_enable    <= 1'b0;
            rc_osc_enable <= 1'b0;
        end else begin
            adc_enable    <= pwr_on_d & ~stop_mode;     // see R9, R14
            rc_osc_enable <= rc_sel_d & ~stop_mode;     // see R9, R14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Multiplexer and sequencer

    // Channel switches follow the code written in the same edge
    adcs_chan_dec u_chan_dec (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .chan      (chan_d),
        .mux_sel_q (mux_select)
    );

    // Sampling window then eight comparison steps, repeating
    adcs_sar u_sar (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .run       (run),
        .restart   (wr_ctrl),                   // see R18
        .step_en   (step_en),
        .comp_high (comp_high),
        .sample_q  (sample_switch),
        .code_q    (dac_code),
        .conv_done (conv_done),
        .conv_code (conv_code)
    );

endmodule // adcs_top
`default_nettype wire

// *** inc/adcs_regs.vh ***
// Register map, field positions and timing counts of the converter control
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// Register indices; byte address is four times the index
`define ADCS_PORT_IDX        8'h03
`define ADCS_RESULT_IDX      8'h08
`define ADCS_CTRL_IDX        8'h09
`define ADCS_PORT_ADDR       8'h0C
`define ADCS_RESULT_ADDR     8'h20
`define ADCS_CTRL_ADDR       8'h24

// Control/status field positions
`define ADCS_DONE_BIT        7
`define ADCS_RCSEL_BIT       6
`define ADCS_PWR_BIT         5
`define ADCS_RSVD_BIT        4
`define ADCS_CHAN_MSB        3
`define ADCS_CHAN_LSB        0

// Reset values
`define ADCS_RESULT_RST      8'h00
`define ADCS_CHAN_RST        4'h0

// Channel codes with special meaning
`define ADCS_CHAN_HIGH_REF   4'h8
`define ADCS_CHAN_MID_REF    4'h9

// Sampling window in bus clock cycles, and counter terminal value
`define ADCS_SAMPLE_CYCLES   12
`define ADCS_SAMPLE_LAST     4'hB

`endif

// *** logic/adcs_chan_dec.v ***
// Registered decode of the channel code into one-hot multiplexer switches
`default_nettype none
`include "adcs_regs.vh"

module adcs_chan_dec (
    // Clock and reset
    input  wire        hclk,
    input  wire        hresetn,
    // Channel code
    input  wire [3:0]  chan,
    // One-hot switches: 7..0 external, 8 high, 9 mid, 10 low reference
    output reg  [10:0] mux_sel_q
);

    // Codes 0..7 pick inputs, 8 high, 9 midpoint, the rest low reference
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mux_sel_q <= 11'h001;
        end else if (!chan[3]) begin
            mux_sel_q <= {3'h0, 8'h01 << chan[2:0]};  // see R12
        end else if (chan == `ADCS_CHAN_HIGH_REF) begin
            mux_sel_q <= 11'h100;                     // see R12
        end else if (chan == `ADCS_CHAN_MID_REF) begin
            mux_sel_q <= 11'h200;                     // see R12
        end else begin
            mux_sel_q <= 11'h400;                     // see R12
        end
    end

endmodule // adcs_chan_dec
`default_nettype wire

// *** logic/adcs_sar.v ***
// Sampling window and eight-bit successive approximation sequencer
`default_nettype none
`include "adcs_regs.vh"

module adcs_sar (
    // Clock and reset
    input  wire       hclk,
    input  wire       hresetn,
    // Control
    input  wire       run,
    input  wire       restart,
    input  wire       step_en,
    input  wire       comp_high,
    // Status and analog drive
    output reg        sample_q,
    output reg  [7:0] code_q,
    output reg        conv_done,
    output reg  [7:0] conv_code
);

    localparam S_IDLE = 3'b001;
    localparam S_SAMP = 3'b010;
    localparam S_CONV = 3'b100;

    reg [2:0] state_q, state_d;
    reg [3:0] cnt_q, cnt_d;
    reg [7:0] mask_q, mask_d;
    reg [7:0] code_d;
    reg [7:0] kept;

    // Next state; abort and power-off override a finishing conversion
    always @* begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        mask_d    = mask_q;
        code_d    = code_q;
        conv_done = 1'b0;
        kept      = comp_high ? code_q : (code_q & ~mask_q);
        conv_code = kept;
        if (!run) begin
            state_d = S_IDLE;                          // see R21
        end else if (restart || state_q == S_IDLE) begin
            state_d = S_SAMP;                          // see R18
            cnt_d   = 4'h0;
        end else begin
            case (state_q)
                S_SAMP: begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == `ADCS_SAMPLE_LAST) begin
                        state_d = S_CONV;              // see R17
                        mask_d  = 8'h80;
                        code_d  = 8'h80;
                    end
                end
                S_CONV: begin
                    if (step_en) begin
                        code_d = kept;                 // see R19
                        mask_d = mask_q >> 1;
                        if (mask_q[0]) begin
                            conv_done = 1'b1;          // see R5
                            state_d   = S_SAMP;
                            cnt_d     = 4'h0;
                        end else begin
                            code_d = kept | (mask_q >> 1);
                        end
                    end
                end
                default: state_d = S_IDLE;
            endcase
        end
    end

    // State registers; switch closed only while sampling
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= S_IDLE;
            cnt_q    <= 4'h0;
            mask_q   <= 8'h00;
            code_q   <= 8'h00;
            sample_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            mask_q   <= mask_d;
            code_q   <= code_d;
            sample_q <= (state_d == S_SAMP);           // see R17
        end
    end

endmodule // adcs_sar
`default_nettype wire

// *** tb/adcs_top_asserts.sv ***
// Port checker for the converter control block
`default_nettype none
module adcs_top_asserts (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Pins and front end
    input wire logic [7:0]  analog_port_pins,
    input wire logic        stop_mode,
    input wire logic        adc_enable,
    input wire logic        rc_osc_enable,
    input wire logic [10:0] mux_select,
    input wire logic        sample_switch,
    input wire logic [7:0]  dac_code
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       wr_q;
    logic [7:0] wd_q;
    logic       stp_q;
    logic [4:0] win_q;
    wire        rd_en = hsel && htrans[1] && hready && !hwrite;
    ////////////////////////////////////////////////////////////////////
    // Expected one-hot switch for a channel code
    function automatic logic [10:0] dec(input logic [3:0] c);
        return c < 4'h8 ? 11'h001 << c : c == 4'h8 ? 11'h100 :
               c == 4'h9 ? 11'h200 : 11'h400;
    endfunction
    // Control write in its data phase, and the data it carries
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_q <= 1'b0;
        else wr_q <= hsel && htrans[1] && hready && hwrite &&
                     haddr[7:0] == 8'h24;
    end
    always_ff @(posedge hclk) begin
        wd_q  <= hwdata[7:0];
        stp_q <= stop_mode;
    end
    // Consecutive closed-switch cycles; a control write starts a new window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) win_q <= 5'd0;
        else if (!sample_switch || wr_q) win_q <= 5'd0;
        else if (win_q != 5'd31) win_q <= win_q + 5'd1;
    end
    ////////////////////////////////////////////////////////////////////
    cfg_apply_a: assert property (wr_q |=>
        mux_select == dec(wd_q[3:0]) && adc_enable == (wd_q[5] && !stp_q)
        && rc_osc_enable == (wd_q[6] && !stp_q)) else $error("cfg apply");
    write_restart_a: assert property (
        wr_q && hwdata[5] && !stop_mode |=> sample_switch)
        else $error("no restart");
    stop_off_a: assert property (
        stop_mode |=> !adc_enable && !rc_osc_enable) else $error("stop");
    idle_off_a: assert property (
        !adc_enable [*2] |-> !sample_switch) else $error("idle off");
    sample_len_a: assert property (
        @(posedge hclk) disable iff (!hresetn || wr_q || stop_mode ||
        !adc_enable) $fell(sample_switch) |-> win_q == 5'd12)
        else $error("sample window short");
    sample_max_a: assert property (
        sample_switch |-> win_q < 5'd12) else $error("sample window long");
    first_trial_a: assert property (
        @(posedge hclk) disable iff (!hresetn || stop_mode || !adc_enable)
        $fell(sample_switch) |-> dac_code == 8'h80) else $error("trial");
    port_read_a: assert property (
        rd_en && haddr[7:0] == 8'h0C |=>
        hrdata == {24'h0, $past(analog_port_pins)}) else $error("port");
    ctrl_read_a: assert property (
        rd_en && haddr[7:0] == 8'h24 |=> hrdata[31:8] == 24'h0 &&
        !hrdata[4] && !hresp) else $error("ctrl read");
    cover property (wr_q && hwdata[6] && hwdata[5]);
    cover property ($fell(sample_switch));
    cover property ($rose(stop_mode) && adc_enable);
endmodule // adcs_top_asserts
bind adcs_top adcs_top_asserts chk (.*);
`default_nettype wire

// *** tb/adcs_afe_model.sv ***
// Analog front end model: multiplexer, held sample and comparator
`default_nettype none
module adcs_afe_model (
    // Clock
    input wire logic        hclk,
    // Drive from the block
    input wire logic        adc_enable,
    input wire logic [10:0] mux_select,
    input wire logic        sample_switch,
    input wire logic [7:0]  dac_code,
    // Comparator out
    output logic            comp_high
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] held_q;
    logic [7:0] lvl;
    logic       tog_q = 1'b0;
    // Level on the selected switch; references are full, half and zero
    always_comb begin
        lvl = 8'h00;
        for (int i = 0; i < 8; i++)
            if (mux_select[i]) lvl = 8'h1D * i[7:0] + 8'h03;
        if (mux_select[8]) lvl = 8'hFF;
        if (mux_select[9]) lvl = 8'h80;
    end
    // Capacitor follows input only while the switch is closed
    always @(posedge hclk) begin
        tog_q <= ~tog_q;
        if (sample_switch) held_q <= lvl;
    end
    // Powered-down comparator gives no usable answer
    assign comp_high = adc_enable ? held_q >= dac_code : tog_q;
endmodule // adcs_afe_model
`default_nettype wire

// *** tb/adcs_tb.sv ***
// Register-level testbench of the converter control block
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
    num_errors++; $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, stop = 0, tick = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [1:0] htrans = 0, tcnt = 0;
    logic [7:0] pins = 0;
    wire [31:0] hrdata;
    wire [10:0] mux;
    wire [7:0] dac;
    wire hrdy, hresp, comp, adc_en, rc_en, samp;
    int num_errors = 0, tests_run = 0, cyc = 0;
    adcs_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
        .hresp(hresp), .analog_port_pins(pins), .stop_mode(stop),
        .rc_osc_tick(tick), .comp_high(comp), .adc_enable(adc_en),
        .rc_osc_enable(rc_en), .mux_select(mux), .sample_switch(samp),
        .dac_code(dac));
    adcs_afe_model afe (.hclk(hclk), .adc_enable(adc_en),
        .mux_select(mux), .sample_switch(samp), .dac_code(dac),
        .comp_high(comp));
    ////////////////////////////////////////////////////////////////////
    // Clock, oscillator ticks every fourth cycle, and hang guard
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        tcnt <= tcnt + 2'd1;
        tick <= tcnt == 2'd3;
        cyc  <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            test_done;
        end
    end
    // One single-word bus transfer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= w;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0, q);
    endtask
    // Poll the control register until the done flag shows
    task automatic wait_done;
        int n;
        n = 0;
        q = 32'h0;
        while (q[7] !== 1'b1 && n < 60) begin
            rd(8'h24);
            n++;
        end
        `CHK("done", 1'b1, q[7])
    endtask
    function automatic logic [31:0] lvl(input logic [3:0] c);
        return c < 8 ? 8'h1D * c + 8'h03 : c == 8 ? 8'hFF :
               c == 9 ? 8'h80 : 8'h00;
    endfunction
    task automatic test_done;
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h24); `CHK("ctrl", 32'h0, q)
        rd(8'h20); `CHK("result", 32'h0, q)
        rd(8'h00); `CHK("unmapped", 32'h0, q)
        pins <= 8'hA5;
        rd(8'h0C); `CHK("port", 32'hA5, q)
        for (int c = 0; c < 16; c++) begin
            wr(8'h24, 32'hB0 | c);
            wait_done;
            `CHK("ctrl", 32'hA0 | c, q)
            rd(8'h20); `CHK("result", lvl(c), q)
            rd(8'h24); `CHK("flag", 1'b0, q[7])
        end
        pins <= 8'h3C;
        rd(8'h0C); `CHK("port", 32'h3C, q)
        wait_done;
        wr(8'h24, 32'h2F);
        rd(8'h24); `CHK("abort", 32'h2F, q)
        for (int m = 0; m < 4; m++) begin
            wr(8'h24, (m << 5) | 3);
            @(negedge hclk);
            `CHK("pwr", m[0], adc_en)
            `CHK("osc", m[1], rc_en)
        end
        wait_done;
        rd(8'h20); `CHK("rc result", lvl(4'h3), q)
        stop <= 1'b1;
        wr(8'h24, 32'h61);
        @(negedge hclk);
        `CHK("stop", 2'b00, {adc_en, rc_en})
        repeat (60) @(posedge hclk);
        rd(8'h24); `CHK("stopped", 32'h61, q)
        stop <= 1'b0;
        wait_done;
        rd(8'h20); `CHK("resume", 32'h20, q)
        wr(8'h24, 32'h0);
        repeat (40) @(posedge hclk);
        rd(8'h24); `CHK("off", 32'h0, q)
        wr(8'h24, 32'h6F);
        wait_done;
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(8'h24); `CHK("ctrl", 32'h0, q)
        rd(8'h20); `CHK("result", 32'h0, q)
        test_done;
    end
endmodule // tb
`default_nettype wire
